//--- logic/idp_consts.svh
/*
 Constants of the division sign-preparation stage: opcode words, compare
 values, register indices, bus offsets and status bit positions.
 Assumes inclusion by bare name from the stage module and the testbench top.
*/
`ifndef IDP_CONSTS_SVH
`define IDP_CONSTS_SVH

// Low opcode words of the six preparation operations
`define IDP_OP_S32 16'hE568
`define IDP_OP_U32 16'hE569
`define IDP_OP_S64_32 16'hE5A8
`define IDP_OP_U64_32 16'hE5A9
`define IDP_OP_S64 16'hE5B8
`define IDP_OP_U64 16'hE5B9

// Most negative values used by the overflow compares
`define IDP_MIN32 32'h8000_0000
`define IDP_MIN64 64'h8000_0000_0000_0000
// Compare value of the 64-bit unsigned-denominator form, kept as printed
`define IDP_MIN_U64_PRINTED 64'h0000_8000_0000_0000

// Extended register indices
`define IDP_R0 3'h0
`define IDP_R1 3'h1
`define IDP_R2 3'h2
`define IDP_R3 3'h3
`define IDP_R4 3'h4
`define IDP_R5 3'h5

// Bus byte offsets; extended register n sits at 4*n
`define IDP_ADDR_EXT_BASE 8'h00
`define IDP_ADDR_STF 8'h20
`define IDP_ADDR_IRQ_STAT 8'h24
`define IDP_ADDR_IRQ_MASK 8'h28

// Interrupt status bit positions
`define IDP_IRQ_OVF 0
`define IDP_IRQ_DONE 1
`define IDP_IRQ_BADOP 2
`define IDP_IRQ_W 3

// Reset values and bus responses
`define IDP_STF_RESET 7'h00
`define IDP_RESP_OKAY 2'h0
`define IDP_RESP_SLVERR 2'h2

`endif

//--- logic/idp_pkg.sv
/*
 Types of the division sign-preparation stage.
 Assumes idp_consts.svh on the include path.
*/
`default_nettype none
package idp_pkg;
    // Floating status register, highest bit first
    typedef struct packed {
        logic sticky_overflow_flag;
        logic sticky_underflow_flag;
        logic float_negative_flag;
        logic float_zero_flag;
        logic remainder_sign_flag;
        logic zero_integer_flag;
        logic quotient_sign_flag;
    } idp_stf_t;

    typedef logic [7:0][31:0] idp_regs_t;
endpackage : idp_pkg
`default_nettype wire

//--- logic/idp_cond_neg.sv
/*
 Conditional two's-complement negation of one operand.
 Assumes a narrower operand is zero-extended; its low bits stay correct.
*/
`timescale 1ns/1ns
`default_nettype none
module idp_cond_neg #(
    parameter int W = 64
) (
    // Operand
    input wire logic [W-1:0] val_in,
    input wire logic neg_in,
    // Result
    output logic [W-1:0] res_out
);
    // Full-width add so the carry crosses the word boundary
    assign res_out = neg_in ? (~val_in + {{(W-1){1'b0}}, 1'b1}) : val_in;
endmodule : idp_cond_neg
`default_nettype wire

//--- logic/idp_ext_regfile.sv
/*
 Eight 32-bit extended registers with a write enable per register.
 Assumes at most one writer per register per cycle, arbitrated upstream.
*/
`timescale 1ns/1ns
`default_nettype none
module idp_ext_regfile
    import idp_pkg::*;
#(
    parameter int NREG = 8
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Write port
    input wire logic [NREG-1:0] we_in,
    input wire logic [NREG-1:0][31:0] wdata_in,
    // Read port
    output logic [NREG-1:0][31:0] rdata_out
);
    logic [31:0] mem_ff [NREG];

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < NREG; i++) begin
                mem_ff[i] <= 32'h0000_0000;
            end
        end else begin
            for (int i = 0; i < NREG; i++) begin
                if (we_in[i]) begin
                    mem_ff[i] <= wdata_in[i];
                end
            end
        end
    end

    for (genvar g = 0; g < NREG; g++) begin : g_rd
        assign rdata_out[g] = mem_ff[g];
    end
endmodule : idp_ext_regfile
`default_nettype wire

//--- logic/idp_sign_prep.sv
/*
 Sign-extraction and operand-conditioning stage for fast integer division,
 with the extended register file, the floating status flags, an interrupt
 status/mask pair and an AXI4-Lite slave for software access.
 Assumes the decoder presents one low opcode word per cycle, synchronous
 to clk_sys_in.
*/
// Our own choices: the AXI4-Lite register port and the address map.
// How it works
// - Opcode E568: signed 32/32 prep; numerator reg1, denominator reg3, remainder reg2.
// - Signed 32/32: remainder sign is numerator bit 31, quotient sign their XOR.
// - Every prep zeroes the remainder and replaces negative operands by magnitude.
// - Opcode E569: unsigned-denominator 32-bit prep; both signs from numerator bit 31.
// - Opcode E5A8: signed 64/32 prep; numerator pair upper word in reg1.
// - Signed 64/32: overflow on most negative 64-bit numerator or 32-bit denominator.
// - Opcode E5A9: 64/32 unsigned denominator; overflow on numerator minimum only.
// - Opcode E5B8: signed 64/64; denominator pair upper in reg3; quotient sign XOR.
// - Signed 64/64: overflow when either 64-bit operand is the most negative value.
// - Opcode E5B9: 64-bit unsigned denominator; clears remainder pair; compare as printed.
// - Preps change only quotient sign, remainder sign and overflow flags.
// - Each prep completes in one cycle; results usable by the next instruction.
// - Registers are fixed by the opcode; preps use extended registers 0 to 5 of the eight.
`timescale 1ns/1ns
`default_nettype none
`include "idp_consts.svh"
module idp_sign_prep
    import idp_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // Instruction from the decoder
    input wire logic instr_valid_in,
    input wire logic [15:0] opcode_in,
    // Status towards the pipeline
    output logic instr_done_out,
    output idp_stf_t stf_out,
    output logic irq_out,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    function automatic logic is_min64(input logic [63:0] v);
        return v == `IDP_MIN64;
    endfunction : is_min64
    function automatic logic is_min32(input logic [31:0] v);
        return v == `IDP_MIN32;
    endfunction : is_min32
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a < `IDP_ADDR_STF) || (a == `IDP_ADDR_STF) || (a == `IDP_ADDR_IRQ_STAT)
            || (a == `IDP_ADDR_IRQ_MASK);
    endfunction : is_mapped
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
        end
        return r;
    endfunction : merge
    // Reset release through two flops
    logic [1:0] rst_sync_ff;
    logic rstn_s;
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rstn_s = rst_sync_ff[1];
    // Register file
    idp_regs_t regs;
    logic [7:0] rf_we;
    idp_regs_t rf_wdata;
    idp_ext_regfile #(.NREG(8)) u_regs (.clk_in(clk_sys_in), .rstn_in(rstn_s), .we_in(rf_we),
        .wdata_in(rf_wdata), .rdata_out(regs));
    wire [31:0] r0 = regs[`IDP_R0];
    wire [31:0] r1 = regs[`IDP_R1];
    wire [31:0] r3 = regs[`IDP_R3];
    wire [31:0] r5 = regs[`IDP_R5];
    // Opcode decode
    wire op_s32 = opcode_in == `IDP_OP_S32;
    wire op_u32 = opcode_in == `IDP_OP_U32;
    wire op_s6432 = opcode_in == `IDP_OP_S64_32;
    wire op_u6432 = opcode_in == `IDP_OP_U64_32;
    wire op_s64 = opcode_in == `IDP_OP_S64;
    wire op_u64 = opcode_in == `IDP_OP_U64;
    wire op_any = op_s32 | op_u32 | op_s6432 | op_u6432 | op_s64 | op_u64;
    wire take = instr_valid_in & op_any;
    wire bad_op = instr_valid_in & ~op_any;
    wire num_wide = op_s6432 | op_u6432 | op_s64 | op_u64;
    wire den_wide = op_s64;
    wire den_signed = op_s32 | op_s6432 | op_s64;
    wire rem_wide = op_s64 | op_u64;
    // Operands, sign bits and magnitudes
    wire [63:0] num_val = num_wide ? {r1, r0} : {32'h0000_0000, r1};
    wire [63:0] den_val = den_wide ? {r3, r5} : {32'h0000_0000, r3};
    wire num_sign = r1[31];
    wire den_sign = r3[31];
    wire [63:0] num_abs, den_abs;
    idp_cond_neg #(.W(64)) u_num_neg (.val_in(num_val), .neg_in(num_sign),
        .res_out(num_abs));
    idp_cond_neg #(.W(64)) u_den_neg (.val_in(den_val), .neg_in(den_signed & den_sign),
        .res_out(den_abs));
    wire quot_sign = den_signed ? (num_sign ^ den_sign) : num_sign;
    wire ovf_hit = (op_s32 & (is_min32(r1) | is_min32(r3)))
        | (op_u32 & is_min32(r1))
        | (op_s6432 & (is_min64(num_val) | is_min32(r3)))
        | (op_u6432 & is_min64(num_val))
        | (op_s64 & (is_min64(num_val) | is_min64(den_val)))
        | (op_u64 & (num_val == `IDP_MIN_U64_PRINTED));
    // Bus write path; held off while an instruction owns the registers
    logic aw_hold_ff, w_hold_ff, awready_ff, wready_ff, bvalid_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic [1:0] bresp_ff;
    wire do_write = aw_hold_ff & w_hold_ff & ~bvalid_ff & ~instr_valid_in;
    wire aw_take = s_axi_awvalid & awready_ff;
    wire w_take = s_axi_wvalid & wready_ff;
    wire nxt_aw_hold = do_write ? 1'b0 : (aw_hold_ff | aw_take);
    wire nxt_w_hold = do_write ? 1'b0 : (w_hold_ff | w_take);
    wire wr_ext = do_write & (aw_addr_ff < `IDP_ADDR_STF);
    wire [2:0] wr_idx = aw_addr_ff[4:2];
    wire wr_stf = do_write & (aw_addr_ff == `IDP_ADDR_STF);
    wire wr_istat = do_write & (aw_addr_ff == `IDP_ADDR_IRQ_STAT);
    wire wr_imask = do_write & (aw_addr_ff == `IDP_ADDR_IRQ_MASK);
    always_ff @(posedge clk_sys_in or negedge rstn_s) begin
        if (!rstn_s) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `IDP_RESP_OKAY;
            aw_addr_ff <= '0;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
        end else begin
            aw_hold_ff <= nxt_aw_hold;
            w_hold_ff <= nxt_w_hold;
            awready_ff <= ~nxt_aw_hold;
            wready_ff <= ~nxt_w_hold;
            if (aw_take) aw_addr_ff <= s_axi_awaddr;
            if (w_take) begin
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (do_write) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= is_mapped(aw_addr_ff) ? `IDP_RESP_OKAY : `IDP_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end
    // Register file write data: instruction results, else the bus
    always_comb begin
        rf_we = '0;
        rf_wdata = regs;
        if (take) begin
            rf_we[`IDP_R1] = 1'b1;
            rf_we[`IDP_R2] = 1'b1;
            rf_wdata[`IDP_R2] = 32'h0000_0000;
            rf_wdata[`IDP_R1] = num_wide ? num_abs[63:32] : num_abs[31:0];
            if (num_wide) begin
                rf_we[`IDP_R0] = 1'b1;
                rf_wdata[`IDP_R0] = num_abs[31:0];
            end
            if (rem_wide) begin
                rf_we[`IDP_R4] = 1'b1;
                rf_wdata[`IDP_R4] = 32'h0000_0000;
            end
            if (den_signed) begin
                rf_we[`IDP_R3] = 1'b1;
                rf_wdata[`IDP_R3] = den_wide ? den_abs[63:32] : den_abs[31:0];
            end
            if (den_wide) begin
                rf_we[`IDP_R5] = 1'b1;
                rf_wdata[`IDP_R5] = den_abs[31:0];
            end
        end else if (wr_ext) begin
            rf_we[wr_idx] = 1'b1;
            rf_wdata[wr_idx] = merge(regs[wr_idx], w_data_ff, w_strb_ff);
        end
    end
    // Status flags and interrupts
    idp_stf_t stf_ff, nxt_stf, stf_wr;
    logic [`IDP_IRQ_W-1:0] irq_stat_ff, irq_mask_ff, nxt_irq_stat, nxt_irq_mask;
    logic done_ff, irq_ff;
    wire [`IDP_IRQ_W-1:0] irq_ev;
    assign stf_wr = idp_stf_t'(7'(merge({25'h0, stf_ff}, w_data_ff, w_strb_ff)));
    assign irq_ev = {bad_op, take, take & ovf_hit};
    always_comb begin
        nxt_stf = wr_stf ? stf_wr : stf_ff;
        if (take) begin
            // Only these three flags move; the rest hold
            nxt_stf.quotient_sign_flag = quot_sign;
            nxt_stf.remainder_sign_flag = num_sign;
            nxt_stf.sticky_overflow_flag = stf_ff.sticky_overflow_flag | ovf_hit;
        end
    end
    // Set wins over a same-cycle write-one-to-clear
    assign nxt_irq_stat = (irq_stat_ff & ~(wr_istat ? w_data_ff[`IDP_IRQ_W-1:0]
                                                    : {`IDP_IRQ_W{1'b0}})) | irq_ev;
    assign nxt_irq_mask = wr_imask ? w_data_ff[`IDP_IRQ_W-1:0] : irq_mask_ff;
    always_ff @(posedge clk_sys_in or negedge rstn_s) begin
        if (!rstn_s) begin
            stf_ff <= `IDP_STF_RESET;
            irq_stat_ff <= '0;
            irq_mask_ff <= '0;
            done_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            stf_ff <= nxt_stf;
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= nxt_irq_mask;
            done_ff <= take;
            irq_ff <= |(nxt_irq_stat & nxt_irq_mask);
        end
    end
    // Bus read path
    logic arready_ff, rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    wire ar_take = s_axi_arvalid & arready_ff;
    wire nxt_rvalid = ar_take ? 1'b1 : (rvalid_ff & ~s_axi_rready);
    wire [31:0] rd_word = (s_axi_araddr < `IDP_ADDR_STF) ? regs[s_axi_araddr[4:2]]
        : (s_axi_araddr == `IDP_ADDR_STF) ? {25'h0, stf_ff}
        : (s_axi_araddr == `IDP_ADDR_IRQ_STAT) ? {29'h0, irq_stat_ff}
        : (s_axi_araddr == `IDP_ADDR_IRQ_MASK) ? {29'h0, irq_mask_ff} : 32'h0000_0000;
    always_ff @(posedge clk_sys_in or negedge rstn_s) begin
        if (!rstn_s) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `IDP_RESP_OKAY;
        end else begin
            arready_ff <= ~nxt_rvalid;
            rvalid_ff <= nxt_rvalid;
            if (ar_take) begin
                rdata_ff <= rd_word;
                rresp_ff <= is_mapped(s_axi_araddr) ? `IDP_RESP_OKAY : `IDP_RESP_SLVERR;
            end
        end
    end
    assign instr_done_out = done_ff;
    assign stf_out = stf_ff;
    assign irq_out = irq_ff;
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    // Checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_s);
    property p_done;
        take |=> instr_done_out ##1 !instr_done_out || $past(take);
    endproperty
    a_done: assert property (p_done) else $error("prep did not finish in one cycle");
    property p_rem_clr;
        take |=> regs[`IDP_R2] == 32'h0000_0000;
    endproperty
    a_rem_clr: assert property (p_rem_clr) else $error("remainder not cleared");
    property p_s32_sign;
        instr_valid_in && op_s32 |=> stf_out.quotient_sign_flag == ($past(r1[31]) ^ $past(r3[31]))
            && stf_out.remainder_sign_flag == $past(r1[31]);
    endproperty
    a_s32_sign: assert property (p_s32_sign) else $error("signed 32 sign flags wrong");
    property p_u32;
        instr_valid_in && op_u32 |=> stf_out.quotient_sign_flag == $past(r1[31])
            && r3 == $past(r3);
    endproperty
    a_u32: assert property (p_u32) else $error("unsigned denom form wrong");
    property p_s32_ovf;
        instr_valid_in && op_s32 && (r1 == `IDP_MIN32 || r3 == `IDP_MIN32)
            |=> stf_out.sticky_overflow_flag;
    endproperty
    a_s32_ovf: assert property (p_s32_ovf) else $error("signed 32 overflow missed");
    property p_ovf_sticky;
        stf_out.sticky_overflow_flag && !wr_stf |=> stf_out.sticky_overflow_flag;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag dropped");
    property p_neg64;
        take && num_wide && r1[31] |=> {r1, r0} == 64'(-$past(num_val));
    endproperty
    a_neg64: assert property (p_neg64) else $error("64-bit negation wrong");
    property p_keep;
        take |=> stf_out.zero_integer_flag == $past(stf_out.zero_integer_flag)
            && stf_out.float_zero_flag == $past(stf_out.float_zero_flag)
            && stf_out.sticky_underflow_flag == $past(stf_out.sticky_underflow_flag);
    endproperty
    a_keep: assert property (p_keep) else $error("untouched flag changed");
    property p_u64_pair;
        instr_valid_in && op_u64 |=> regs[`IDP_R4] == 32'h0000_0000 && r3 == $past(r3);
    endproperty
    a_u64_pair: assert property (p_u64_pair) else $error("remainder pair not cleared");
    property p_s64_q;
        instr_valid_in && op_s64 |=> stf_out.quotient_sign_flag == $past(r1[31] ^ r3[31]);
    endproperty
    a_s64_q: assert property (p_s64_q) else $error("64/64 quotient sign wrong");
    c_ovf: cover property (take && ovf_hit);
    c_s64_neg: cover property (instr_valid_in && op_s64 && r1[31] && r3[31]);
    c_irq: cover property (!irq_out ##1 irq_out);
endmodule : idp_sign_prep
`default_nettype wire

//--- testbench/idp_dec_model.sv
/*
 Decoder model: hands the stage one low opcode word per requested cycle.
 Assumes requests are driven just after the rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module idp_dec_model (
    // Clock and request
    input wire logic clk_in,
    input wire logic req_in,
    input wire logic [15:0] req_op_in,
    // Towards the stage
    output logic instr_valid_out,
    output logic [15:0] opcode_out
);
    initial begin
        instr_valid_out = 1'b0;
        opcode_out = 16'h0000;
    end
    // Idle word toggles, so a stale opcode never looks fresh
    always @(posedge clk_in) begin
        instr_valid_out <= req_in;
        opcode_out <= req_in ? req_op_in : ~opcode_out;
    end
endmodule : idp_dec_model
`default_nettype wire

//--- testbench/idp_sign_prep_tb_top.sv
/*
 Self-checking bench of the division sign-preparation stage.
 Assumes the package, constants header and decoder model compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "idp_consts.svh"
module idp_sign_prep_tb_top
    import idp_pkg::*;
;
    logic clk = 1'b0, rstn = 1'b0, req = 1'b0;
    logic [15:0] req_op = 16'h0000;
    logic instr_valid, done, irq;
    logic [15:0] opcode;
    idp_stf_t float_status_register, m_stf;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int err_count = 0;
    int n_tests = 0;
    logic [1:0] q_b[$];
    logic [33:0] q_r[$];
    idp_stf_t q_s[$];
    logic [31:0] m[8];
    logic [2:0] m_irq = 3'h0;
    logic [31:0] rnd = 32'hF533_B8C4;
    logic [15:0] ops[6] = '{`IDP_OP_S32, `IDP_OP_U32, `IDP_OP_S64_32, `IDP_OP_U64_32,
                            `IDP_OP_S64, `IDP_OP_U64};
    logic [15:0] op;
    int k;

    initial begin
        forever #20 clk = ~clk;
    end

    idp_dec_model idp_dec_model_i (.clk_in(clk), .req_in(req), .req_op_in(req_op),
        .instr_valid_out(instr_valid), .opcode_out(opcode));
    idp_sign_prep idp_sign_prep_i (.clk_sys_in(clk), .rstn_in(rstn),
        .instr_valid_in(instr_valid), .opcode_in(opcode), .instr_done_out(done),
        .stf_out(float_status_register), .irq_out(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
        logic pa, pw, ta, tw;
        q_b.push_back(rsp);
        pa = 1'b1;
        pw = 1'b1;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Address and data may be taken on different edges
        while (pa || pw) begin
            @(negedge clk);
            ta = pa && awready === 1'b1;
            tw = pw && wready === 1'b1;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        do @(negedge clk); while (bvalid !== 1'b1);
        @(posedge clk);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
        q_r.push_back({rsp, d});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (rvalid !== 1'b1);
        @(posedge clk);
        rready <= 1'b0;
    endtask : rd

    task automatic go(input logic [15:0] a, input logic [15:0] b, input bit two);
        @(posedge clk);
        req <= 1'b1;
        req_op <= a;
        if (two) begin
            @(posedge clk);
            req_op <= b;
        end
        @(posedge clk);
        req <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : go

    // Reference result of one prep, noted before it is issued
    task automatic calc(input logic [15:0] o);
        logic wide, dd, sd, ov;
        logic [63:0] n, d;
        wide = o[7:4] != 4'h6;
        dd = o[7:4] == 4'hB;
        sd = !o[0];
        n = {m[1], m[0]};
        d = {m[3], m[5]};
        ov = wide ? (n == (o == `IDP_OP_U64 ? `IDP_MIN_U64_PRINTED : `IDP_MIN64))
                  : (m[1] == `IDP_MIN32);
        if (sd) ov = ov | (dd ? (d == `IDP_MIN64) : (m[3] == `IDP_MIN32));
        m_stf.quotient_sign_flag = m[1][31] ^ (sd & m[3][31]);
        m_stf.remainder_sign_flag = m[1][31];
        m_stf.sticky_overflow_flag = m_stf.sticky_overflow_flag | ov;
        m_irq = m_irq | {1'b0, 1'b1, ov};
        if (m[1][31] && wide) {m[1], m[0]} = -n;
        else if (m[1][31]) m[1] = -m[1];
        if (sd && m[3][31] && dd) {m[3], m[5]} = -d;
        else if (sd && m[3][31]) m[3] = -m[3];
        m[2] = 32'h0;
        if (dd) m[4] = 32'h0;
        q_s.push_back(m_stf);
    endtask : calc

    always @(negedge clk) begin
        if (bvalid === 1'b1 && bready === 1'b1) check("bresp", bresp, q_b.pop_front());
        if (rvalid === 1'b1 && rready === 1'b1) check("rdata", {rresp, rdata}, q_r.pop_front());
        if (done === 1'b1 && q_s.size() == 0) check("extra done", 1'b1, 1'b0);
        else if (done === 1'b1) check("stf", float_status_register, q_s.pop_front());
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        finish_test();
    end

    initial begin
        m = '{default: 32'h0};
        m_stf = '0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        rd(`IDP_ADDR_STF, 32'h0, `IDP_RESP_OKAY);
        rd(`IDP_ADDR_IRQ_MASK, 32'h0, `IDP_RESP_OKAY);
        rd(8'h30, 32'h0, `IDP_RESP_SLVERR);
        wr(8'h30, rnd, `IDP_RESP_SLVERR);
        for (int i = 0; i < 24; i++) begin
            op = ops[i % 6];
            k = i / 6;
            for (int r = 0; r < 8; r++) begin
                rnd = lfsr(rnd);
                m[r] = rnd;
            end
            // Boundary operands: minimum numerator, then minimum denominator
            if (k == 1) m[1] = op == `IDP_OP_U64 ? 32'h0000_8000 : `IDP_MIN32;
            if (k == 1) m[0] = 32'h0;
            if (k == 2) m[3] = `IDP_MIN32;
            if (k == 2) m[5] = 32'h0;
            for (int r = 0; r < 8; r++) wr(8'(4 * r), m[r], `IDP_RESP_OKAY);
            m_stf = k == 3 ? rnd[6:0] : rnd[6:0] & 7'h3F;
            wr(`IDP_ADDR_STF, 32'(m_stf), `IDP_RESP_OKAY);
            calc(op);
            go(op, op, 1'b0);
            for (int r = 0; r < 6; r++) rd(8'(4 * r), m[r], `IDP_RESP_OKAY);
        end
        // Back to back: the second prep must see the first one's results
        wr(8'h04, 32'hFFFF_FFF9, `IDP_RESP_OKAY);
        wr(8'h0C, 32'hFFFF_FFFD, `IDP_RESP_OKAY);
        m[1] = 32'hFFFF_FFF9;
        m[3] = 32'hFFFF_FFFD;
        calc(`IDP_OP_S32);
        calc(`IDP_OP_S64);
        go(`IDP_OP_S32, `IDP_OP_S64, 1'b1);
        for (int r = 0; r < 6; r++) rd(8'(4 * r), m[r], `IDP_RESP_OKAY);
        rd(`IDP_ADDR_IRQ_STAT, 32'(m_irq), `IDP_RESP_OKAY);
        check("irq masked", irq, 1'b0);
        wr(`IDP_ADDR_IRQ_MASK, 32'h7, `IDP_RESP_OKAY);
        repeat (2) @(negedge clk);
        check("irq", irq, 1'b1);
        wr(`IDP_ADDR_IRQ_STAT, 32'h3, `IDP_RESP_OKAY);
        repeat (2) @(negedge clk);
        check("irq cleared", irq, 1'b0);
        go(16'hE564, 16'h0000, 1'b0);
        rd(`IDP_ADDR_IRQ_STAT, 32'h4, `IDP_RESP_OKAY);
        rd(`IDP_ADDR_STF, 32'(m_stf), `IDP_RESP_OKAY);
        check("irq bad op", irq, 1'b1);
        wr(`IDP_ADDR_IRQ_MASK, 32'h3, `IDP_RESP_OKAY);
        rd(`IDP_ADDR_IRQ_MASK, 32'h3, `IDP_RESP_OKAY);
        check("irq remasked", irq, 1'b0);
        finish_test();
    end
endmodule : idp_sign_prep_tb_top
`default_nettype wire
